// *** logic/msif_pkg.sv ***
// constants and field layout of the motion status and interrupt flag block
// Notes on behaviour
// (R1) live flag byte read-only, resets to zero
// (R2) incline flag gated by incline feature enable
// (R3) overturn flag gated by incline feature enable
// (R4) movement flag gated by any-motion enable
// (R5) jolt flag gated by shake enable
// (R6) incline-35 flag gated by tilt-35 enable
// (R7) host should poll pending flags, not live
// (R8) queue-any flag is OR of fifo indications
// (R9) sample-ready only when active; read clears it
// (R10) sample-ready sets on each new sample written
// (R11) host reads status at output data rate
// (R12) pending bit needs its interrupt enable set
// (R13) default write clears all pending bits
// (R14) per-source select: write clears masked bits only
// (R15) pending byte resets zero, same bit layout
// (R16) fifo empty, full, level reached indications
// (R17) motion pending bits latch until cleared
// (R18) sample and queue pending bits set rules
package msif_pkg;
   localparam logic [7:0] MSIF_LIVE_ADDR = 8'h13;
   localparam logic [7:0] MSIF_PEND_ADDR = 8'h14;
   localparam logic [7:0] MSIF_RESET_VAL = 8'h00;
   localparam int MSIF_B_INCL   = 0;
   localparam int MSIF_B_OVER   = 1;
   localparam int MSIF_B_MOVE   = 2;
   localparam int MSIF_B_JOLT   = 3;
   localparam int MSIF_B_INC35  = 4;
   localparam int MSIF_B_QUEUE  = 5;
   localparam int MSIF_B_RESV   = 6;
   localparam int MSIF_B_SAMPLE = 7;
   // motion control enable bits (overturn shares incline enable)
   localparam int MSIF_MC_INCL  = 0;
   localparam int MSIF_MC_MOVE  = 2;
   localparam int MSIF_MC_JOLT  = 3;
   localparam int MSIF_MC_INC35 = 4;
   // fifo status / fifo interrupt enable bits
   localparam int MSIF_Q_EMPTY  = 0;
   localparam int MSIF_Q_FULL   = 1;
   localparam int MSIF_Q_LEVEL  = 2;
endpackage

// *** logic/msif_flags.sv ***
// live event flags and latched pending interrupt flags
`timescale 1ns/1ns
module msif_flags
   import msif_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] motion_ctrl,
   input  wire logic [7:0] irq_enable,
   input  wire logic [2:0] queue_irq_enable,
   input  wire logic       per_source_clear_select,
   input  wire logic       active_sampling,
   input  wire logic       sample_written,
   input  wire logic       incline_det,
   input  wire logic       overturn_det,
   input  wire logic       movement_det,
   input  wire logic       jolt_det,
   input  wire logic       incline35_det,
   input  wire logic       queue_empty,
   input  wire logic       queue_full,
   input  wire logic       queue_level_reached,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_rd,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic      [7:0] live_event_flags,
   output logic      [7:0] pending_interrupt_flags
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // live flags
   // ----------------------------------------------------------------
   logic       sample_ready_r;
   logic [7:0] live_nxt;
   logic [2:0] queue_vec;
   logic       read_live;
   logic       write_pend;

   assign queue_vec  = {queue_level_reached, queue_full, queue_empty}; // [R16]
   // one decode shared by the read path and the flag logic
   function automatic logic addr_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
      return strobe && (addr == target);
   endfunction

   assign read_live  = addr_hit(reg_rd, reg_addr, MSIF_LIVE_ADDR);
   assign write_pend = addr_hit(reg_wr, reg_addr, MSIF_PEND_ADDR);

   always_comb
   begin
      live_nxt                = MSIF_RESET_VAL;
      live_nxt[MSIF_B_INCL]   = motion_ctrl[MSIF_MC_INCL] & incline_det;    // [R2]
      live_nxt[MSIF_B_OVER]   = motion_ctrl[MSIF_MC_INCL] & overturn_det;   // [R3]
      live_nxt[MSIF_B_MOVE]   = motion_ctrl[MSIF_MC_MOVE] & movement_det;   // [R4]
      live_nxt[MSIF_B_JOLT]   = motion_ctrl[MSIF_MC_JOLT] & jolt_det;       // [R5]
      live_nxt[MSIF_B_INC35]  = motion_ctrl[MSIF_MC_INC35] & incline35_det; // [R6]
      live_nxt[MSIF_B_QUEUE]  = |queue_vec;                                 // [R8]
      live_nxt[MSIF_B_SAMPLE] = sample_ready_r;
   end

   // new sample wins over a read in the same cycle
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         sample_ready_r <= 1'b0;
      else if (active_sampling && sample_written)
         sample_ready_r <= 1'b1;                       // [R10] [R9]
      else if (read_live)
         sample_ready_r <= 1'b0;                       // [R9]
   end

   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         live_event_flags <= MSIF_RESET_VAL;            // [R1]
      else
         live_event_flags <= live_nxt;
   end

   // ----------------------------------------------------------------
   // pending interrupt flags
   // ----------------------------------------------------------------
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic       move_on;

   // jolt and incline-35 also need any-motion running
   assign move_on = motion_ctrl[MSIF_MC_MOVE];

   always_comb
   begin
      set_vec                = MSIF_RESET_VAL;
      set_vec[MSIF_B_INCL]   = irq_enable[MSIF_B_INCL] & live_nxt[MSIF_B_INCL];   // [R17]
      set_vec[MSIF_B_OVER]   = irq_enable[MSIF_B_OVER] & live_nxt[MSIF_B_OVER];   // [R17]
      set_vec[MSIF_B_MOVE]   = irq_enable[MSIF_B_MOVE] & live_nxt[MSIF_B_MOVE];   // [R17]
      set_vec[MSIF_B_JOLT]   = irq_enable[MSIF_B_JOLT] & move_on
                               & live_nxt[MSIF_B_JOLT];                          // [R17]
      set_vec[MSIF_B_INC35]  = irq_enable[MSIF_B_INC35] & move_on
                               & live_nxt[MSIF_B_INC35];                         // [R17]
      set_vec[MSIF_B_QUEUE]  = |(queue_irq_enable & queue_vec);                  // [R18]
      set_vec[MSIF_B_SAMPLE] = irq_enable[MSIF_B_SAMPLE] & active_sampling
                               & sample_written;                                 // [R18] [R12]
      set_vec[MSIF_B_RESV]   = 1'b0;
   end

   always_comb
   begin
      clr_vec = MSIF_RESET_VAL;
      if (write_pend)
      begin
         if (per_source_clear_select)
            clr_vec = reg_wdata;                       // [R14]
         else
            clr_vec = 8'hFF;                           // [R13]
      end
   end

   // set wins over clear so no event is lost
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         pending_interrupt_flags <= MSIF_RESET_VAL;     // [R15]
      else
         pending_interrupt_flags <= (pending_interrupt_flags & ~clr_vec) | set_vec; // [R12]
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_sync_r)
   begin
      if (!rst_sync_r)
         reg_rdata <= MSIF_RESET_VAL;
      else if (read_live)
         reg_rdata <= live_event_flags;
      else if (addr_hit(reg_rd, reg_addr, MSIF_PEND_ADDR))
         reg_rdata <= pending_interrupt_flags;
      else if (reg_rd)
         reg_rdata <= MSIF_RESET_VAL;
   end
endmodule

// *** verif/msif_monitor.sv ***
// port assertions for the flag block
`timescale 1ns/1ns
module msif_monitor
   import msif_pkg::*;
(
   input wire logic       core_clk, reset_n, per_source_clear_select, reg_rd, reg_wr,
   input wire logic       active_sampling, sample_written, incline_det,
   input wire logic       queue_empty, queue_full, queue_level_reached,
   input wire logic [7:0] motion_ctrl, irq_enable, reg_addr, reg_wdata,
   input wire logic [7:0] reg_rdata, live_event_flags, pending_interrupt_flags
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic pw = reg_wr && reg_addr == MSIF_PEND_ADDR;
   wire logic lr = reg_rd && reg_addr == MSIF_LIVE_ADDR;
   a_resv_zero: assert property (
      !live_event_flags[6] && !pending_interrupt_flags[6]) else $error("bit 6 set");
   a_incl_live: assert property (
      live_event_flags[0] == $past(incline_det && motion_ctrl[0])) else $error("incline");
   a_queue_or: assert property (
      live_event_flags[5] == $past(queue_empty | queue_full | queue_level_reached))
      else $error("queue flag");
   a_read_live: assert property (lr |=> reg_rdata == $past(live_event_flags))
      else $error("read data");
   a_ready_set: assert property (
      sample_written && active_sampling |-> ##[1:2] live_event_flags[7]) else $error("set");
   a_ready_clear: assert property (
      lr && !sample_written ##1 !sample_written |=> !live_event_flags[7]) else $error("clr");
   a_clear_all: assert property (
      pw && !per_source_clear_select && irq_enable == 8'h00
      |=> (pending_interrupt_flags & 8'hDF) == 8'h00) else $error("clear all");
   a_mask_keep: assert property (pw && per_source_clear_select |=>
      ($past(pending_interrupt_flags) & ~$past(reg_wdata) & ~pending_interrupt_flags) == 8'h00)
      else $error("mask clear");
   cover property (pw && per_source_clear_select);
   cover property (lr && live_event_flags[7]);
   cover property (pending_interrupt_flags[7]);
endmodule

// *** verif/msif_host.sv ***
// host model driving single byte register reads and writes
`timescale 1ns/1ns
module msif_host (
   input wire logic  core_clk,
   output logic [7:0] reg_addr, reg_wdata,
   output logic       reg_rd, reg_wr
);
   initial {reg_addr, reg_wdata, reg_rd, reg_wr} = '0;
   // one access per call, strobe held high for one clock cycle
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge core_clk);
      #2 {reg_addr, reg_wdata, reg_rd, reg_wr} = {a, d, !w, w};
      @(posedge core_clk);
      // released lines show no stale value
      #2 {reg_addr, reg_wdata, reg_rd, reg_wr} = {~a, ~d, 2'b00};
   endtask
endmodule

// *** verif/motion_status_and_irq_flags_test.sv ***
// self-checking bench for the flag block
`timescale 1ns/1ns
module motion_status_and_irq_flags_test;
   import msif_pkg::*;
   logic       core_clk = 0, reset_n = 0, sel = 0, act = 1, sw = 0, rd_d = 0;
   logic [7:0] mc = 0, ie = 0, lf = 8'h36, eq[$];
   logic [4:0] det = 0;
   logic [2:0] q = 0, qie = 0;
   wire logic [7:0] addr, wd, rdata;
   wire logic  rd, wr;
   int         mismatches = 0, checks = 0, cyc = 0;
   msif_host u_msif_host (.core_clk, .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd));
   msif_flags u_msif_flags (.core_clk, .reset_n, .motion_ctrl(mc), .irq_enable(ie),
      .queue_irq_enable(qie), .per_source_clear_select(sel), .active_sampling(act),
      .sample_written(sw), .incline_det(det[0]), .overturn_det(det[1]), .movement_det(det[2]),
      .jolt_det(det[3]), .incline35_det(det[4]), .queue_empty(q[0]), .queue_full(q[1]),
      .queue_level_reached(q[2]), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd),
      .reg_rdata(rdata), .live_event_flags(), .pending_interrupt_flags());
   initial forever #10 core_clk = ~core_clk;
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic rc(input logic [7:0] a, e);
      eq.push_back(e);
      u_msif_host.acc(1'b0, a, 8'h00);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // result watcher: one registered answer per read
   always @(posedge core_clk)
   begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (rd_d)
         check(rdata, eq.pop_front());
      if (cyc == 2000)
      begin
         mismatches++;
         wrap_up;
      end
   end
   initial
   begin
      tick(5);
      reset_n = 1;
      tick(3);
      rc(MSIF_LIVE_ADDR, 8'h00);
      rc(MSIF_PEND_ADDR, 8'h00);
      rc(8'h7E, 8'h00);
      repeat (6)
      begin
         lf = nxt(lf);
         mc = lf;
         lf = nxt(lf);
         {det, q} = lf;
         tick(2);
         rc(MSIF_LIVE_ADDR, {2'b00, |q, det[4:2] & mc[4:2], det[1:0] & {2{mc[0]}}});
      end
      {mc, det, q, sw} = {8'hFF, 9'h001};
      tick(1);
      sw = 0;
      tick(2);
      rc(MSIF_LIVE_ADDR, 8'h80);
      tick(2);
      rc(MSIF_LIVE_ADDR, 8'h00);
      {act, sw} = 2'b01;
      tick(1);
      sw = 0;
      tick(2);
      rc(MSIF_LIVE_ADDR, 8'h00);
      {act, sw, ie, det, q, qie} = {2'b11, 8'hFF, 5'h15, 6'h32};
      tick(1);
      {sw, det, q} = 9'h000;
      tick(2);
      rc(MSIF_PEND_ADDR, 8'hB5);
      {sel, ie} = 9'h100;
      u_msif_host.acc(1'b1, MSIF_PEND_ADDR, 8'h05);
      u_msif_host.acc(1'b1, MSIF_LIVE_ADDR, 8'hFF);
      rc(MSIF_PEND_ADDR, 8'hB0);
      sel = 0;
      u_msif_host.acc(1'b1, MSIF_PEND_ADDR, 8'h00);
      rc(MSIF_PEND_ADDR, 8'h00);
      {det, sw} = 6'h3F;
      tick(1);
      sw = 0;
      tick(2);
      rc(MSIF_PEND_ADDR, 8'h00);
      tick(4);
      wrap_up;
   end
endmodule
bind msif_flags msif_monitor u_msif_monitor (.*);
